//--- logic/glitch_filter.sv
// input glitch filter with selectable width
// assumes input already synchronous to the clock
`timescale 1ns/10ps
`include "tmr_ctl_defs.svh"
module glitch_filter (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire tmr_ctl_pkg::filter_sel_t sel,
  // signal
  input wire logic din,
  output logic dout
);
  import tmr_ctl_pkg::*;
  logic [`FILTER_CNT_W-1:0] cnt_q;
  logic [`FILTER_CNT_W-1:0] need;
  logic cand_q;
  always_comb begin
    case (sel)
      FLT_SHORT: need = `FILTER_CNT_W'(`FILTER_SHORT_CYCLES);
      FLT_LONG: need = `FILTER_CNT_W'(`FILTER_LONG_CYCLES);
      default: need = '0;
    endcase
  end
  // new level must hold need cycles before it passes
  always_ff @(posedge clk) begin
    if (rst) begin
      cand_q <= 1'b0;
      cnt_q <= '0;
      dout <= 1'b0;
    end else if (sel == FLT_NONE || sel == FLT_RESERVED) begin
      cand_q <= din;
      cnt_q <= '0;
      dout <= din;
    end else if (din != cand_q) begin
      cand_q <= din;
      cnt_q <= `FILTER_CNT_W'(1);
    end else if (din != dout) begin
      if (cnt_q >= need - `FILTER_CNT_W'(1))
        dout <= din;
      else
        cnt_q <= cnt_q + `FILTER_CNT_W'(1);
    end
  end
endmodule : glitch_filter

//--- logic/timer_pair_ctrl.sv
// common control of an 8-bit and 16-bit timer pair, AHB-Lite slave
// assumes one clock, synchronous inputs, single word transfers
// Summary of operation
// - transmit sub-mode 00 is normal, 01 alternating, 00 after reset.
// - demod field picks filter: none, 4 cycles, 8 cycles, 11 reserved.
// - transmit bit 1 is the 8-bit timer start level, read/write.
// - demod read of bit 1 shows the rising-edge flag.
// - demod write 1 to bit 1 clears the rising flag, 0 does nothing.
// - transmit bit 0 is the 16-bit timer start level, read/write.
// - demod read of bit 0 shows falling flag; writing 0 has no effect.
// - mode bit 0 selects transmit, 1 selects demodulation.
// - demod write 1 to bit 0 clears the falling flag.
// - forced-low acts at once; back to normal ends alternating.
// - an idle timer output rests at the inverse of its start level, except the 16-bit one in the forced sub-modes.
`timescale 1ns/10ps
`include "tmr_ctl_defs.svh"
module timer_pair_ctrl (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // timer side
  input wire logic EIGHT_RUN,
  input wire logic SIXTEEN_RUN,
  input wire logic EIGHT_TOGGLE,
  input wire logic SIXTEEN_TOGGLE,
  input wire logic DEMOD_IN,
  output tmr_ctl_pkg::timer_outs_t TIMER_OUTS,
  output logic ALTERNATE_ACTIVE,
  // interrupt
  output logic IRQ
);
  import tmr_ctl_pkg::*;

  common_ctrl_t ctrl_q;
  logic rise_q;
  logic fall_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [1:0] tmr_en_q;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [31:0] rdata_d;
  logic acc;
  logic wr_ctrl;
  logic demod;
  logic filt_out;
  logic filt_prev_q;
  logic rise_ev;
  logic fall_ev;
  logic eight_run_q;
  logic sixteen_run_q;
  logic eight_out_q;
  logic sixteen_out_q;
  logic [7:0] wd;
  sub_mode_t sub;

  assign acc = HSEL && HREADY && HTRANS[1];
  assign wr_ctrl = wr_pend_q && (wr_addr_q == `OFF_COMMON_CTRL);
  assign wd = HWDATA[7:0];
  assign demod = ctrl_q.mode;
  assign sub = sub_mode_t'(ctrl_q.sub);
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // address phase capture for writes
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= acc && HWRITE;
      wr_addr_q <= {HADDR[11:2], 2'b00};
    end
  end

  // control register; low bits stored in transmit meaning
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl_q <= common_ctrl_t'(`COMMON_CTRL_RESET);
    end else if (wr_ctrl) begin
      ctrl_q.mode <= wd[`BIT_MODE];
      ctrl_q.upper <= wd[`BIT_MODE-1:`FLD_SUB_HI+1];
      ctrl_q.sub <= wd[`FLD_SUB_HI:`FLD_SUB_LO];
      if (!wd[`BIT_MODE]) begin
        ctrl_q.eight_bit_start_level <= wd[`BIT_EIGHT_START];
        ctrl_q.sixteen_bit_start_level <=
          wd[`BIT_SIXTEEN_START];
      end
    end
  end

  // demodulator input filter
  glitch_filter u_filter (
    .clk(CORE_CLK),
    .rst(RST),
    .sel(filter_sel_t'(ctrl_q.sub)),
    .din(DEMOD_IN),
    .dout(filt_out)
  );

  always_ff @(posedge CORE_CLK) begin
    if (RST)
      filt_prev_q <= 1'b0;
    else
      filt_prev_q <= filt_out;
  end

  assign rise_ev = demod && filt_out && !filt_prev_q;
  assign fall_ev = demod && !filt_out && filt_prev_q;

  // edge flags: set wins over write-one clear
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      if (rise_ev)
        rise_q <= 1'b1;
      else if (wr_ctrl && demod && wd[`BIT_EIGHT_START])
        rise_q <= 1'b0;
      if (fall_ev)
        fall_q <= 1'b1;
      else if (wr_ctrl && demod && wd[`BIT_SIXTEEN_START])
        fall_q <= 1'b0;
    end
  end

  // interrupt status, mask and timer enables
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      tmr_en_q <= '0;
    end else begin
      if (wr_pend_q && wr_addr_q == `OFF_IRQ_MASK)
        irq_mask_q <= HWDATA[1:0];
      if (wr_pend_q && wr_addr_q == `OFF_TIMER_EN)
        tmr_en_q <= HWDATA[1:0];
      for (int i = 0; i < 2; i++) begin
        if ((i == `IRQ_RISE) ? rise_ev : fall_ev)
          irq_stat_q[i] <= 1'b1;
        else if (wr_pend_q && wr_addr_q == `OFF_IRQ_STATUS && HWDATA[i])
          irq_stat_q[i] <= 1'b0;
      end
    end
  end

  assign IRQ = |(irq_stat_q & irq_mask_q);

  // timer outputs: idle at inverse start unless the 16-bit one is forced, load start on enable
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      eight_run_q <= 1'b0;
      sixteen_run_q <= 1'b0;
      eight_out_q <= 1'b1;
      sixteen_out_q <= 1'b1;
    end else begin
      eight_run_q <= EIGHT_RUN && tmr_en_q[0] && !demod;
      sixteen_run_q <= SIXTEEN_RUN && tmr_en_q[1] && !demod;
      if (!(EIGHT_RUN && tmr_en_q[0]) || demod)
        eight_out_q <= !ctrl_q.eight_bit_start_level;
      else if (!eight_run_q)
        eight_out_q <= ctrl_q.eight_bit_start_level;
      else if (EIGHT_TOGGLE)
        eight_out_q <= !eight_out_q;
      if (!demod && sub == SUB_FORCE_LOW)
        sixteen_out_q <= 1'b0;
      else if (!demod && sub == SUB_FORCE_HIGH)
        sixteen_out_q <= 1'b1;
      else if (!(SIXTEEN_RUN && tmr_en_q[1]) || demod)
        sixteen_out_q <= !ctrl_q.sixteen_bit_start_level;
      else if (!sixteen_run_q)
        sixteen_out_q <= ctrl_q.sixteen_bit_start_level;
      else if (SIXTEEN_TOGGLE)
        sixteen_out_q <= !sixteen_out_q;
    end
  end

  assign TIMER_OUTS.eight_bit_timer_output = eight_out_q;
  assign TIMER_OUTS.sixteen_bit_timer_output = sixteen_out_q;
  // normal sub-mode ends alternating
  assign ALTERNATE_ACTIVE = !demod && sub == SUB_ALTERNATE;

  // read data, registered in the data phase
  always_comb begin
    rdata_d = '0;
    case ({HADDR[11:2], 2'b00})
      `OFF_COMMON_CTRL: begin
        rdata_d[7:0] = ctrl_q;
        if (demod) begin
          rdata_d[`BIT_EIGHT_START] = rise_q;
          rdata_d[`BIT_SIXTEEN_START] = fall_q;
        end
      end
      `OFF_IRQ_STATUS: rdata_d[1:0] = irq_stat_q;
      `OFF_IRQ_MASK: rdata_d[1:0] = irq_mask_q;
      `OFF_TIMER_EN: rdata_d[1:0] = tmr_en_q;
      `OFF_PIN_STATE: rdata_d[2:0] = {filt_out, eight_out_q, sixteen_out_q};
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST)
      HRDATA <= '0;
    else if (acc && !HWRITE)
      HRDATA <= rdata_d;
  end
endmodule : timer_pair_ctrl

//--- logic/tmr_ctl_defs.svh
// constants for the timer-pair common control block
// assumes inclusion by the design modules
`ifndef TMR_CTL_DEFS_SVH
`define TMR_CTL_DEFS_SVH
`define OFF_COMMON_CTRL 12'h000
`define OFF_IRQ_STATUS 12'h004
`define OFF_IRQ_MASK 12'h008
`define OFF_TIMER_EN 12'h00C
`define OFF_PIN_STATE 12'h010
`define BIT_SIXTEEN_START 0
`define BIT_EIGHT_START 1
`define FLD_SUB_LO 2
`define FLD_SUB_HI 3
`define BIT_MODE 7
`define COMMON_CTRL_RESET 8'h00
`define FILTER_SHORT_CYCLES 4
`define FILTER_LONG_CYCLES 8
`define FILTER_CNT_W 4
`define IRQ_RISE 0
`define IRQ_FALL 1
`endif

//--- logic/tmr_ctl_pkg.sv
// types for the timer-pair common control block
// assumes tmr_ctl_defs.svh in the include path
package tmr_ctl_pkg;
  typedef enum logic [1:0] {
    SUB_NORMAL = 2'b00,
    SUB_ALTERNATE = 2'b01,
    SUB_FORCE_LOW = 2'b10,
    SUB_FORCE_HIGH = 2'b11
  } sub_mode_t;
  typedef enum logic [1:0] {
    FLT_NONE = 2'b00,
    FLT_SHORT = 2'b01,
    FLT_LONG = 2'b10,
    FLT_RESERVED = 2'b11
  } filter_sel_t;
  typedef struct packed {
    logic mode;
    logic [2:0] upper;
    logic [1:0] sub;
    logic eight_bit_start_level;
    logic sixteen_bit_start_level;
  } common_ctrl_t;
  typedef struct packed {
    logic eight_bit_timer_output;
    logic sixteen_bit_timer_output;
  } timer_outs_t;
endpackage : tmr_ctl_pkg

//--- testbench/demod_source.sv
// modulated line driven into the demodulator input
// assumes pulses are requested between bus transfers
`timescale 1ns/10ps
module demod_source (
  // clock
  input wire logic clk,
  // modulated line, idles low
  output logic din
);
  initial din = 1'h0;
  // high for n clocks, then back to the idle level
  task automatic pulse(input int n);
    @(posedge clk);
    din <= 1'h1;
    repeat (n) @(posedge clk);
    din <= 1'h0;
  endtask : pulse
endmodule : demod_source

//--- testbench/tb_timer_pair_ctrl.sv
// self-checking bench of the timer-pair common control block
// assumes the design files and demod_source compiled before it
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t: %h %h", $time, a, b); end end
module tb_timer_pair_ctrl;
  import tmr_ctl_pkg::*;
  logic CORE_CLK = 1'h0, RST = 1'h1, HWRITE = 1'h0, f;
  logic [1:0] HTRANS = 2'h0, run = 2'h0, tog = 2'h0, lv;
  logic [11:0] HADDR = 12'h000;
  logic [31:0] HWDATA = 32'h0, HRDATA, r;
  logic HREADY, HRESP, IRQ, ALT, DEMOD_IN;
  timer_outs_t TIMER_OUTS;
  int err_total = 0, comparisons = 0, ctl;
  timer_pair_ctrl dut (.CORE_CLK(CORE_CLK), .RST(RST), .HSEL(1'h1),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
    .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADY), .HRESP(HRESP), .EIGHT_RUN(run[1]),
    .SIXTEEN_RUN(run[0]), .EIGHT_TOGGLE(tog[1]), .SIXTEEN_TOGGLE(tog[0]),
    .DEMOD_IN(DEMOD_IN), .TIMER_OUTS(TIMER_OUTS),
    .ALTERNATE_ACTIVE(ALT), .IRQ(IRQ));
  demod_source src (.clk(CORE_CLK), .din(DEMOD_IN));
  initial forever #10 CORE_CLK = ~CORE_CLK;
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  // address phase, then data phase, each held until ready
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    @(posedge CORE_CLK);
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do @(posedge CORE_CLK); while (HREADY !== 1'h1 && ++n < 50);
      if (HREADY !== 1'h1) begin
        err_total++;
        end_sim;
      end
      HTRANS <= 2'h0;
      HWDATA <= d;
    end
    r = HRDATA;
  endtask : xfer
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    xfer(1'h0, a, 32'h0);
    `CHK(r, x);
  endtask : rd
  initial begin
    void'($urandom(7));
    repeat (3) @(posedge CORE_CLK);
    RST <= 1'h0;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    `CHK({TIMER_OUTS, IRQ, ALT}, 4'hC);
    xfer(1'h1, 12'h020, 32'hFF);
    rd(12'h020, 32'h0);
    for (int s = 0; s < 4; s++) begin
      lv = 2'($urandom);
      ctl = s << 2 | lv | ($urandom & 32'h70);
      xfer(1'h1, 12'h000, ctl);
      rd(12'h000, ctl);
      `CHK(ALT, s == 1);
      `CHK(TIMER_OUTS, {~lv[1], s > 1 ? s[0] : ~lv[0]});
    end
    xfer(1'h1, 12'h000, 32'h2);
    xfer(1'h1, 12'h00C, 32'h3);
    run <= 2'h3;
    `CHK(TIMER_OUTS, 2'h1);
    repeat (3) @(posedge CORE_CLK);
    `CHK(TIMER_OUTS, 2'h2);
    tog <= 2'h3;
    @(posedge CORE_CLK);
    tog <= 2'h0;
    repeat (2) @(posedge CORE_CLK);
    `CHK(TIMER_OUTS, 2'h1);
    rd(12'h010, 32'h1);
    run <= 2'h0;
    xfer(1'h1, 12'h00C, 32'h0);
    xfer(1'h1, 12'h008, 32'h3);
    for (int s = 0; s < 4; s++) begin
      f = s == 0 || s == 3;
      ctl = 32'h80 | s << 2;
      xfer(1'h1, 12'h000, ctl | 3);
      xfer(1'h1, 12'h004, 32'h3);
      src.pulse(s == 1 ? 3 : s == 2 ? 7 : 1);
      repeat (12) @(posedge CORE_CLK);
      rd(12'h000, ctl | (f ? 3 : 0));
      rd(12'h004, f ? 3 : 0);
      `CHK(IRQ, f);
      src.pulse(12);
      repeat (12) @(posedge CORE_CLK);
      xfer(1'h1, 12'h000, ctl | 1);
      rd(12'h000, ctl | 2);
    end
    xfer(1'h1, 12'h008, 32'h0);
    repeat (2) @(posedge CORE_CLK);
    `CHK(IRQ, 1'h0);
    xfer(1'h1, 12'h008, 32'h3);
    repeat (2) @(posedge CORE_CLK);
    `CHK(IRQ, 1'h1);
    xfer(1'h1, 12'h004, 32'h3);
    rd(12'h004, 32'h0);
    `CHK(IRQ, 1'h0);
    end_sim;
  end
endmodule : tb_timer_pair_ctrl

//--- testbench/timer_pair_ctrl_props.sv
// port checks for the timer-pair common control block
// assumes the zero-wait slave and a single clock domain
`timescale 1ns/10ps
module timer_pair_ctrl_props (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // bus
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // timer side
  input wire logic EIGHT_RUN,
  input wire logic SIXTEEN_RUN,
  input wire tmr_ctl_pkg::timer_outs_t TIMER_OUTS,
  input wire logic ALTERNATE_ACTIVE,
  input wire logic IRQ
);
  import tmr_ctl_pkg::*;
  logic wr_q, rd_q;
  logic [11:0] a_q;
  wire cw = wr_q && a_q == 12'h000;
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  always_ff @(posedge CORE_CLK) begin
    wr_q <= !RST && HSEL && HREADY && HTRANS[1] && HWRITE;
    rd_q <= !RST && HSEL && HREADY && HTRANS[1] && !HWRITE;
    a_q <= HADDR;
  end
  alt_sel_a: assert property (cw |=> ALTERNATE_ACTIVE ==
    $past(!HWDATA[7] && HWDATA[3:2] == 2'h1)) else $error("bad alternate");
  reset_val_a: assert property (disable iff (1'h0) RST |=>
    TIMER_OUTS == 2'h3 && !IRQ && !ALTERNATE_ACTIVE && HRDATA == 32'h0)
    else $error("bad reset state");
  idle_level_a: assert property (cw && !HWDATA[7] && !HWDATA[3]
    ##1 (!EIGHT_RUN && !SIXTEEN_RUN && !cw) [*2]
    |-> TIMER_OUTS == ~$past(HWDATA[1:0], 2)) else $error("bad idle level");
  force_out_a: assert property (cw && !HWDATA[7] && HWDATA[3]
    |-> ##2 TIMER_OUTS.sixteen_bit_timer_output == $past(HWDATA[2], 2))
    else $error("bad forced level");
  mask_off_a: assert property (wr_q && a_q == 12'h008
    && HWDATA[1:0] == 2'h0 |-> ##2 !IRQ) else $error("masked irq seen");
  unmapped_rd_a: assert property (rd_q && a_q > 12'h013
    |-> HRDATA == 32'h0) else $error("unmapped read not zero");
  okay_resp_a: assert property (HREADYOUT && !HRESP)
    else $error("bad bus response");
  alt_hold_a: assert property ($changed(ALTERNATE_ACTIVE)
    |-> $past(cw) || $past(RST)) else $error("alternate moved alone");
  cover property (cw && HWDATA[7]);
  cover property (ALTERNATE_ACTIVE);
  cover property (IRQ);
endmodule : timer_pair_ctrl_props
bind timer_pair_ctrl timer_pair_ctrl_props u_props (.*);
